// ---- bmx_pkg.sv ----
// package: constants of the byte move and exchange core
package bmx_pkg;
    // ----------------------------------------
    // register map and fields
    // ----------------------------------------
    localparam logic [7:0] BMX_OFF_INSN = 8'h00;
    localparam logic [7:0] BMX_OFF_STAT = 8'h04;
    localparam logic [7:0] BMX_OFF_PSW = 8'h08;
    localparam logic [7:0] BMX_OFF_REGLO = 8'h0c;
    localparam logic [7:0] BMX_OFF_REGHI = 8'h10;
    localparam logic [7:0] BMX_OFF_PC = 8'h14;
    localparam int BMX_IN_FORM_LSB = 0;
    localparam int BMX_IN_REG_LSB = 8;
    localparam int BMX_IN_OP_LSB = 16;
    localparam int BMX_FO_Z_LSB = 0;
    localparam int BMX_FO_AC_LSB = 3;
    localparam int BMX_FO_CY_LSB = 6;
    localparam int BMX_PSW_IE = 7;
    localparam int BMX_PSW_Z = 6;
    localparam int BMX_PSW_AC = 4;
    localparam int BMX_PSW_CY = 0;
    localparam logic [7:0] BMX_PSW_RST = 8'h00;
    localparam logic [15:0] BMX_PC_RST = 16'h0000;
    // ----------------------------------------
    // registers and address ranges
    // ----------------------------------------
    localparam logic [2:0] BMX_R_X = 3'h0;
    localparam logic [2:0] BMX_R_A = 3'h1;
    localparam logic [2:0] BMX_R_E = 3'h4;
    localparam logic [2:0] BMX_R_D = 3'h5;
    localparam logic [2:0] BMX_R_L = 3'h6;
    localparam logic [2:0] BMX_R_H = 3'h7;
    localparam logic [1:0] BMX_RP_HL = 2'h3;
    localparam logic [7:0] BMX_SADDR_SPLIT = 8'h20;
    localparam logic [7:0] BMX_PAGE_LO = 8'hfe;
    localparam logic [7:0] BMX_PAGE_HI = 8'hff;
    localparam logic [15:0] BMX_CT_LO = 16'h0040;
    localparam logic [15:0] BMX_CT_HI = 16'h007f;
    // ----------------------------------------
    // forms, timing tables
    // ----------------------------------------
    localparam logic [5:0] BMX_NFORM = 6'h21;
    localparam logic [5:0] F_R_IMM = 6'h00, F_SAD_IMM = 6'h01, F_SFR_IMM = 6'h02;
    localparam logic [5:0] F_A_R = 6'h03, F_R_A = 6'h04, F_A_SAD = 6'h05, F_SAD_A = 6'h06;
    localparam logic [5:0] F_A_SFR = 6'h07, F_SFR_A = 6'h08, F_A_ABS = 6'h09, F_ABS_A = 6'h0a;
    localparam logic [5:0] F_PSW_IMM = 6'h0b, F_A_PSW = 6'h0c, F_PSW_A = 6'h0d;
    localparam logic [5:0] F_A_DE = 6'h0e, F_DE_A = 6'h0f, F_A_HL = 6'h10, F_HL_A = 6'h11;
    localparam logic [5:0] F_A_HLB = 6'h12, F_HLB_A = 6'h13, F_X_A_X = 6'h14, F_X_A_R = 6'h15;
    localparam logic [5:0] F_X_SAD = 6'h16, F_X_SFR = 6'h17, F_X_DE = 6'h18, F_X_HL = 6'h19;
    localparam logic [5:0] F_X_HLB = 6'h1a, F_W_RP_IMM = 6'h1b, F_W_SADP = 6'h1c;
    localparam logic [5:0] F_W_ABS = 6'h1d, F_BR_REL = 6'h1e, F_CALLT = 6'h1f, F_FLAG = 6'h20;
    localparam logic [3:0] BMX_CLOCKS [33] = '{4'h6, 4'h6, 4'h6, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4,
        4'h4, 4'h8, 4'h8, 4'h6, 4'h4, 4'h4, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6, 4'h4, 4'h6,
        4'h6, 4'h6, 4'h8, 4'h8, 4'h8, 4'h6, 4'h6, 4'ha, 4'h6, 4'h6, 4'h4};
    localparam logic [1:0] BMX_BYTES [33] = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
        2'h2, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2,
        2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h1, 2'h2};
    localparam logic [32:0] BMX_RD_M = 33'h0b7c542a0;
    localparam logic [32:0] BMX_WR_M = 33'h007ca8546;
    localparam logic [32:0] BMX_WORD_M = 33'h0b0000000;
    localparam logic [3:0] BMX_STEP_RD = 4'h0;
    localparam logic [3:0] BMX_STEP_RD2 = 4'h1;
    localparam logic [3:0] BMX_STEP_CAP = 4'h2;
    localparam logic [3:0] BMX_STEP_CAP2 = 4'h3;
    localparam logic [3:0] BMX_STEP_WR = 4'h2;
    typedef enum logic [2:0] {BMX_FA_KEEP, BMX_FA_CLR, BMX_FA_SET, BMX_FA_RES, BMX_FA_RESTORE} bmx_fact_t;
    typedef enum logic {ST_IDLE, ST_EXEC} bmx_state_t;
endpackage : bmx_pkg

// ---- bmx_core.sv ----
// module: decode and execution of byte move and exchange forms
// What this block does
// [RQ1] registers 0-7 are X,A,C,B,E,D,L,H
// [RQ2] pairs 0-3 join registers 2n and 2n+1
// [RQ3] short direct FE20-FF1F, word form even
// [RQ4] absolute address full range, even for words
// [RQ5] call table even, 0040 to 007F
// [RQ6] immediates are 16, 8 and 3 bits
// [RQ7] A byte accumulator, pair zero word accumulator
// [RQ8] relative branch adds signed byte to pc
// [RQ9] nmi active flag apart from irq enable
// [RQ10] flags keep, clear, set, result or restore
// [RQ11] register immediate move: 3 bytes, 6 clocks
// [RQ12] accumulator direct move: 2 bytes, 4 clocks
// [RQ13] short direct swap: 2 bytes, 6 clocks, atomic
// [RQ14] swap with sfr: 2 bytes, 6 clocks
// [RQ15] indirect pointer swap: 1 byte, 8 clocks
// [RQ16] offset pointer swap: 2 bytes, 8 clocks
// [RQ17] status byte writes update zero and carries
// [RQ18] move rejects A; register swap rejects A, X
`timescale 1ns/1ps
module bmx_core
    import bmx_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_re,
    output logic mem_we,
    output logic mem_lock,
    input wire logic [7:0] mem_rdata,
    input wire logic nmi_start,
    input wire logic nmi_done
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    bmx_state_t st, next_st;
    logic [3:0] step, next_step;
    logic [5:0] form, next_form;
    logic [2:0] rsel, next_rsel;
    logic [15:0] opnd, next_opnd;
    logic [15:0] addr, next_addr;
    logic [7:0] lo_d, next_lo_d;
    logic [7:0] hi_d, next_hi_d;
    logic [7:0] rf [8];
    logic [7:0] next_rf [8];
    logic [7:0] program_status_byte, next_psw;
    logic [7:0] saved_psw, next_saved_psw;
    logic [15:0] pc, next_pc;
    logic nmi_act, next_nmi_act;
    logic illegal, next_illegal;
    logic [15:0] next_mem_addr;
    logic [7:0] next_mem_wdata;
    logic next_mem_re, next_mem_we, next_mem_lock;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;

    // ----------------------------------------
    // decode of a written instruction
    // ----------------------------------------
    logic idle, apb_acc, wr_insn, wr_psw, wr_pc, start, fin;
    logic [5:0] in_form;
    logic [2:0] in_reg;
    logic [15:0] in_op, in_addr;
    logic in_ill;
    logic [15:0] de_ptr, hl_ptr;

    assign idle = (st == ST_IDLE);
    assign apb_acc = psel & penable & pready & pwrite & idle;
    assign wr_insn = apb_acc & (paddr == BMX_OFF_INSN);
    assign wr_psw = apb_acc & (paddr == BMX_OFF_PSW);
    assign wr_pc = apb_acc & (paddr == BMX_OFF_PC);
    assign in_form = pwdata[BMX_IN_FORM_LSB +: 6];
    assign in_reg = pwdata[BMX_IN_REG_LSB +: 3];
    assign in_op = pwdata[BMX_IN_OP_LSB +: 16]; // RQ6
    assign de_ptr = {rf[BMX_R_D], rf[BMX_R_E]}; // RQ2
    assign hl_ptr = {rf[BMX_R_H], rf[BMX_R_L]}; // RQ2
    assign start = wr_insn & ~in_ill;
    assign fin = (st == ST_EXEC) && (step == BMX_CLOCKS[form] - 4'h1);

    function automatic logic [15:0] saddr_of(input logic [7:0] b);
        saddr_of = (b < BMX_SADDR_SPLIT) ? {BMX_PAGE_HI, b} : {BMX_PAGE_LO, b}; // RQ3
    endfunction : saddr_of

    function automatic logic flag_next(input logic [2:0] act, input logic cur, input logic res,
                                       input logic sav);
        case (bmx_fact_t'(act)) // RQ10
            BMX_FA_CLR: flag_next = 1'b0;
            BMX_FA_SET: flag_next = 1'b1;
            BMX_FA_RES: flag_next = res;
            BMX_FA_RESTORE: flag_next = sav;
            default: flag_next = cur;
        endcase
    endfunction : flag_next

    always_comb begin
        unique case (in_form)
            F_SAD_IMM, F_A_SAD, F_SAD_A, F_X_SAD, F_W_SADP: in_addr = saddr_of(in_op[7:0]);
            F_SFR_IMM, F_A_SFR, F_SFR_A, F_X_SFR: in_addr = {BMX_PAGE_HI, in_op[7:0]};
            F_A_DE, F_DE_A, F_X_DE: in_addr = de_ptr;
            F_A_HL, F_HL_A, F_X_HL: in_addr = hl_ptr;
            F_A_HLB, F_HLB_A, F_X_HLB: in_addr = hl_ptr + {8'h00, in_op[7:0]}; // RQ16
            default: in_addr = in_op; // RQ4
        endcase
        in_ill = (in_form >= BMX_NFORM);
        if ((in_form == F_A_R || in_form == F_R_A) && in_reg == BMX_R_A) begin
            in_ill = 1'b1; // RQ18
        end
        if (in_form == F_X_A_R && (in_reg == BMX_R_A || in_reg == BMX_R_X)) begin
            in_ill = 1'b1; // RQ18
        end
        if ((in_form == F_W_SADP || in_form == F_W_ABS) && in_addr[0]) begin
            in_ill = 1'b1; // RQ3 RQ4
        end
        if (in_form == F_CALLT && (in_addr[0] || in_addr < BMX_CT_LO || in_addr > BMX_CT_HI)) begin
            in_ill = 1'b1; // RQ5
        end
    end

    // ----------------------------------------
    // flag update selection
    // ----------------------------------------
    logic [2:0] act_z, act_ac, act_cy;
    logic [7:0] res_b;

    always_comb begin
        act_z = BMX_FA_KEEP;
        act_ac = BMX_FA_KEEP;
        act_cy = BMX_FA_KEEP;
        res_b = rf[BMX_R_A];
        if (form == F_PSW_IMM || form == F_PSW_A) begin
            act_z = BMX_FA_RES; // RQ17
            act_ac = BMX_FA_RES;
            act_cy = BMX_FA_RES;
            res_b = (form == F_PSW_IMM) ? opnd[7:0] : rf[BMX_R_A];
        end else if (form == F_FLAG) begin
            act_z = opnd[BMX_FO_Z_LSB +: 3]; // RQ6 RQ10
            act_ac = opnd[BMX_FO_AC_LSB +: 3];
            act_cy = opnd[BMX_FO_CY_LSB +: 3];
        end
    end

    // ----------------------------------------
    // execution sequencer
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_step = step;
        next_form = form;
        next_rsel = rsel;
        next_opnd = opnd;
        next_addr = addr;
        next_lo_d = lo_d;
        next_hi_d = hi_d;
        next_rf = rf;
        next_psw = program_status_byte;
        next_pc = pc;
        next_illegal = illegal;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_mem_re = 1'b0;
        next_mem_we = 1'b0;
        next_mem_lock = mem_lock;
        next_nmi_act = (nmi_act & ~nmi_done) | nmi_start; // RQ9
        next_saved_psw = nmi_start ? program_status_byte : saved_psw;
        if (wr_psw) begin
            next_psw = pwdata[7:0];
        end
        if (wr_pc) begin
            next_pc = pwdata[15:0];
        end
        if (wr_insn) begin
            next_illegal = in_ill;
        end
        if (start) begin
            next_st = ST_EXEC;
            next_step = 4'h0;
            next_form = in_form;
            next_rsel = in_reg;
            next_opnd = in_op;
            next_addr = in_addr;
            next_mem_lock = BMX_RD_M[in_form] & BMX_WR_M[in_form]; // RQ13
        end else if (st == ST_EXEC) begin
            next_step = step + 4'h1;
            if (step == BMX_STEP_RD && BMX_RD_M[form]) begin
                next_mem_re = 1'b1;
                next_mem_addr = addr;
            end
            if (step == BMX_STEP_RD2 && BMX_WORD_M[form]) begin
                next_mem_re = 1'b1;
                next_mem_addr = addr + 16'h0001;
            end
            if (step == BMX_STEP_CAP && BMX_RD_M[form]) begin
                next_lo_d = mem_rdata;
            end
            if (step == BMX_STEP_CAP2 && BMX_WORD_M[form]) begin
                next_hi_d = mem_rdata;
            end
            if (step == BMX_STEP_WR && BMX_WR_M[form]) begin
                next_mem_we = 1'b1;
                next_mem_addr = addr;
                next_mem_wdata = (form == F_SAD_IMM || form == F_SFR_IMM) ? opnd[15:8] : rf[BMX_R_A];
            end
            if (fin) begin
                next_st = ST_IDLE;
                next_mem_lock = 1'b0;
                next_pc = pc + {14'h0000, BMX_BYTES[form]};
                next_psw[BMX_PSW_Z] = flag_next(act_z, program_status_byte[BMX_PSW_Z], res_b[BMX_PSW_Z],
                                                saved_psw[BMX_PSW_Z]);
                next_psw[BMX_PSW_AC] = flag_next(act_ac, program_status_byte[BMX_PSW_AC], res_b[BMX_PSW_AC],
                                                 saved_psw[BMX_PSW_AC]);
                next_psw[BMX_PSW_CY] = flag_next(act_cy, program_status_byte[BMX_PSW_CY], res_b[BMX_PSW_CY],
                                                 saved_psw[BMX_PSW_CY]);
                case (form)
                    F_R_IMM: next_rf[rsel] = opnd[7:0]; // RQ11
                    F_A_R: next_rf[BMX_R_A] = rf[rsel]; // RQ1 RQ7
                    F_R_A: next_rf[rsel] = rf[BMX_R_A];
                    F_A_PSW: next_rf[BMX_R_A] = program_status_byte;
                    F_A_SAD, F_A_SFR, F_A_ABS, F_A_DE, F_A_HL, F_A_HLB,
                    F_X_SAD, F_X_SFR, F_X_DE, F_X_HL, F_X_HLB: begin
                        next_rf[BMX_R_A] = lo_d; // RQ12 RQ13 RQ14 RQ15
                    end
                    F_X_A_X, F_X_A_R: begin
                        next_rf[BMX_R_A] = rf[rsel];
                        next_rf[rsel] = rf[BMX_R_A];
                    end
                    F_W_RP_IMM: begin
                        next_rf[{rsel[1:0], 1'b0}] = opnd[7:0]; // RQ2
                        next_rf[{rsel[1:0], 1'b1}] = opnd[15:8];
                    end
                    F_W_SADP, F_W_ABS: begin
                        next_rf[BMX_R_X] = lo_d; // RQ7
                        next_rf[BMX_R_A] = hi_d;
                    end
                    F_BR_REL: begin
                        next_pc = pc + {14'h0000, BMX_BYTES[form]} + {{8{opnd[7]}}, opnd[7:0]}; // RQ8
                    end
                    F_CALLT: next_pc = {hi_d, lo_d}; // RQ5
                    default: next_rf = rf;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_IDLE;
            step <= 4'h0;
            form <= 6'h00;
            rsel <= 3'h0;
            opnd <= 16'h0000;
            addr <= 16'h0000;
            lo_d <= 8'h00;
            hi_d <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                rf[i] <= 8'h00;
            end
            program_status_byte <= BMX_PSW_RST;
            saved_psw <= BMX_PSW_RST;
            pc <= BMX_PC_RST;
            nmi_act <= 1'b0;
            illegal <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
            mem_re <= 1'b0;
            mem_we <= 1'b0;
            mem_lock <= 1'b0;
        end else begin
            st <= next_st;
            step <= next_step;
            form <= next_form;
            rsel <= next_rsel;
            opnd <= next_opnd;
            addr <= next_addr;
            lo_d <= next_lo_d;
            hi_d <= next_hi_d;
            rf <= next_rf;
            program_status_byte <= next_psw;
            saved_psw <= next_saved_psw;
            pc <= next_pc;
            nmi_act <= next_nmi_act;
            illegal <= next_illegal;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            mem_re <= next_mem_re;
            mem_we <= next_mem_we;
            mem_lock <= next_mem_lock;
        end
    end

    // ----------------------------------------
    // apb slave, answer in first access cycle
    // ----------------------------------------
    always_comb begin
        next_pready = psel & ~penable;
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        if (psel & ~penable) begin
            case (paddr)
                BMX_OFF_INSN: begin
                    next_prdata = {opnd, 5'h00, rsel, 2'h0, form};
                    next_pslverr = pwrite & ~idle;
                end
                BMX_OFF_STAT: begin
                    next_prdata = {28'h0000000, mem_lock, nmi_act, illegal, ~idle};
                    next_pslverr = pwrite;
                end
                BMX_OFF_PSW: begin
                    next_prdata = {24'h000000, program_status_byte};
                    next_pslverr = pwrite & ~idle;
                end
                BMX_OFF_REGLO: begin
                    next_prdata = {rf[3], rf[2], rf[1], rf[0]};
                    next_pslverr = pwrite;
                end
                BMX_OFF_REGHI: begin
                    next_prdata = {rf[7], rf[6], rf[5], rf[4]};
                    next_pslverr = pwrite;
                end
                BMX_OFF_PC: begin
                    next_prdata = {16'h0000, pc};
                    next_pslverr = pwrite & ~idle;
                end
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_acc_from_reg: assert property (fin && form == F_A_R |=> rf[BMX_R_A] == $past(rf[rsel])) // RQ1
        else $error("accumulator not loaded from register");
    a_pair_load: assert property (fin && form == F_W_RP_IMM && rsel[1:0] == BMX_RP_HL
        |=> {rf[BMX_R_H], rf[BMX_R_L]} == $past(opnd)) // RQ2
        else $error("pair load wrong");
    a_saddrp_odd: assert property (wr_insn && in_form == F_W_SADP && in_addr[0] |=> illegal && idle) // RQ3
        else $error("odd short word address accepted");
    a_abs_odd: assert property (wr_insn && in_form == F_W_ABS && in_addr[0] |=> illegal) // RQ4
        else $error("odd absolute word address accepted");
    a_ct_range: assert property (wr_insn && in_form == F_CALLT && in_addr < BMX_CT_LO |=> illegal) // RQ5
        else $error("call table address out of range accepted");
    a_rel_branch: assert property (fin && form == F_BR_REL
        |=> pc == $past(pc + 16'h0002 + {{8{opnd[7]}}, opnd[7:0]})) // RQ8
        else $error("relative branch target wrong");
    a_nmi_flag: assert property (nmi_start |=> nmi_act ##0 program_status_byte[BMX_PSW_IE] == $past(program_status_byte[BMX_PSW_IE])) // RQ9
        else $error("nmi flag not set");
    a_imm_six_clk: assert property (st == ST_EXEC && step == 4'h0 && form == F_R_IMM |-> ##5 fin ##1 idle) // RQ11
        else $error("immediate move not six clocks");
    a_dir_four_clk: assert property (st == ST_EXEC && step == 4'h0
        && (form == F_A_SAD || form == F_SFR_A) |-> ##3 fin) // RQ12
        else $error("direct move not four clocks");
    a_swap_lock: assert property (st == ST_EXEC && step == 4'h0 && form == F_X_SAD
        |-> mem_lock [*6] ##1 !mem_lock) // RQ13
        else $error("short swap not locked six clocks");
    a_swap_sfr_flags: assert property (fin && form == F_X_SFR |=> $stable(program_status_byte)) // RQ14
        else $error("sfr swap changed flags");
    a_ind_eight_clk: assert property (st == ST_EXEC && step == 4'h0 && form == F_X_HL |-> ##7 fin) // RQ15
        else $error("indirect swap not eight clocks");
    a_hlb_addr: assert property (st == ST_EXEC && step == 4'h0 && form == F_X_HLB
        |=> mem_re && mem_addr == $past(hl_ptr + {8'h00, opnd[7:0]})) // RQ16
        else $error("offset swap address wrong");
    a_psw_write: assert property (fin && form == F_PSW_A
        |=> program_status_byte[BMX_PSW_Z] == $past(rf[BMX_R_A][BMX_PSW_Z]) && $stable(program_status_byte[BMX_PSW_IE])) // RQ17
        else $error("status byte write wrong");
    a_reg_reject: assert property (wr_insn && in_form == F_X_A_R && in_reg == BMX_R_X |=> illegal && idle) // RQ18
        else $error("swap with X accepted");
endmodule : bmx_core

// ---- bmx_mem_model.sv ----
// partner: byte memory and special register space behind the core
`timescale 1ns/1ps
module bmx_mem_model (
    input wire logic pclk,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_re,
    input wire logic mem_we,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [65536];
    initial begin
        mem_rdata = 8'h00;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
        end
    end
    // ----------------------------------------
    // data one cycle after strobe, churns otherwise
    // ----------------------------------------
    always @(posedge pclk) begin
        if (mem_we === 1'b1) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_re === 1'b1) begin
            mem_rdata <= mem[mem_addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : bmx_mem_model

// ---- tb.sv ----
// testbench: byte move and exchange core
`timescale 1ns/1ps
module tb;
    import bmx_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic mem_re, mem_we, mem_lock, nmi_start, nmi_done;
    logic [7:0] paddr, mem_wdata, mem_rdata;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] mem_addr;
    logic [33:0] e;
    logic [33:0] note_q [$];
    int lock_q [$];
    int fails, n_compared, cyc, lock_len, seed;
    logic [7:0] v [8];
    logic [5:0] bad_f [8] = '{F_A_R, F_R_A, F_X_A_R, F_X_A_R, 6'h21, F_W_SADP, F_W_ABS, F_CALLT};
    logic [2:0] bad_r [8] = '{3'h1, 3'h1, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
    bmx_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .mem_addr, .mem_wdata, .mem_re, .mem_we, .mem_lock, .mem_rdata, .nmi_start, .nmi_done);
    bmx_mem_model mm (.pclk, .mem_addr, .mem_wdata, .mem_re, .mem_we, .mem_rdata);
    always #5 pclk = ~pclk;
    // ----------------------------------------
    // checking, bus tasks, monitors
    // ----------------------------------------
    function automatic logic [7:0] f(input logic [15:0] ad);
        return ad[7:0] ^ ad[15:8] ^ 8'h5a;
    endfunction : f
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [33:0] n);
        note_q.push_back(n);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
    endtask : apb
    task automatic rdx(input logic [7:0] ad, input logic [31:0] x);
        apb(1'b0, ad, 32'h0, {2'b10, x});
    endtask : rdx
    task automatic insn(input logic [5:0] fm, input logic [2:0] r, input logic [15:0] op);
        apb(1'b1, BMX_OFF_INSN, {op, 5'h00, r, 2'b00, fm}, 34'h0);
    endtask : insn
    task automatic busy(input int k);
        repeat (k) rdx(BMX_OFF_STAT, 32'h1);
        rdx(BMX_OFF_STAT, 32'h0);
    endtask : busy
    task automatic wait_done;
        do apb(1'b0, BMX_OFF_STAT, 32'h0, 34'h0); while (rd[0] !== 1'b0);
    endtask : wait_done
    task automatic idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : idle
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = note_q.pop_front();
            check({pslverr, e[33] ? prdata : 32'h0}, e[32:0]);
        end
        if (mem_lock === 1'b1) begin
            lock_len <= lock_len + 1;
        end else if (lock_len != 0) begin
            check(33'(lock_len), 33'(lock_q.pop_front()));
            lock_len <= 0;
        end
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        nmi_start = 0; nmi_done = 0; fails = 0; n_compared = 0; cyc = 0; lock_len = 0; seed = 95;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdx(BMX_OFF_PSW, 32'h0);
        rdx(BMX_OFF_PC, 32'h0);
        rdx(BMX_OFF_REGLO, 32'h0);
        apb(1'b1, BMX_OFF_STAT, 32'h1, {2'b01, 32'h0});
        apb(1'b0, 8'h18, 32'h0, {2'b01, 32'h0});
        $display("test reset done");
        for (int r = 0; r < 8; r++) begin
            v[r] = 8'($random(seed));
            insn(F_R_IMM, 3'(r), {8'h00, v[r]});
            busy(3);
        end
        rdx(BMX_OFF_REGLO, {v[3], v[2], v[1], v[0]});
        rdx(BMX_OFF_REGHI, {v[7], v[6], v[5], v[4]});
        rdx(BMX_OFF_PC, 32'd24);
        $display("test register numbering done");
        for (int i = 0; i < 8; i++) begin
            insn(bad_f[i], bad_r[i], 16'h0021);
            rdx(BMX_OFF_STAT, 32'h2);
        end
        rdx(BMX_OFF_REGLO, {v[3], v[2], v[1], v[0]});
        $display("test rejects done");
        insn(F_SAD_A, 3'h0, 16'h0030);
        busy(2);
        insn(F_A_SAD, 3'h0, 16'h0010);
        busy(2);
        rdx(BMX_OFF_REGLO, {v[3], v[2], f(16'hff10), v[0]});
        insn(F_A_SAD, 3'h0, 16'h0030);
        busy(2);
        rdx(BMX_OFF_REGLO, {v[3], v[2], v[1], v[0]});
        rdx(BMX_OFF_PSW, 32'h0);
        $display("test short direct done");
        insn(F_W_RP_IMM, 3'h2, 16'h1234);
        busy(3);
        insn(F_W_RP_IMM, 3'(BMX_RP_HL), 16'h2000);
        busy(3);
        rdx(BMX_OFF_REGHI, 32'h20001234);
        lock_q = '{6, 8, 8, 8, 6, 6};
        insn(F_X_SAD, 3'h0, 16'h0040);
        wait_done();
        insn(F_X_DE, 3'h0, 16'h0000);
        wait_done();
        insn(F_X_HL, 3'h0, 16'h0000);
        wait_done();
        insn(F_X_HLB, 3'h0, 16'h0005);
        wait_done();
        rdx(BMX_OFF_REGLO, {v[3], v[2], f(16'h2005), v[0]});
        insn(F_X_SAD, 3'h0, 16'h0040);
        wait_done();
        rdx(BMX_OFF_REGLO, {v[3], v[2], v[1], v[0]});
        insn(F_A_HLB, 3'h0, 16'h0005);
        wait_done();
        rdx(BMX_OFF_REGLO, {v[3], v[2], f(16'h2000), v[0]});
        rdx(BMX_OFF_PSW, 32'h0);
        $display("test swaps done");
        insn(F_PSW_IMM, 3'h0, 16'h00ff);
        busy(3);
        rdx(BMX_OFF_PSW, 32'h51);
        insn(F_FLAG, 3'h0, 16'h004a);
        busy(2);
        rdx(BMX_OFF_PSW, 32'h40);
        insn(F_A_PSW, 3'h0, 16'h0000);
        busy(2);
        rdx(BMX_OFF_REGLO, {v[3], v[2], 8'h40, v[0]});
        $display("test flags done");
        idle();
        nmi_start <= 1'b1;
        @(posedge pclk);
        nmi_start <= 1'b0;
        rdx(BMX_OFF_STAT, 32'h4);
        rdx(BMX_OFF_PSW, 32'h40);
        idle();
        nmi_done <= 1'b1;
        @(posedge pclk);
        nmi_done <= 1'b0;
        rdx(BMX_OFF_STAT, 32'h0);
        idle();
        idle();
        $display("test nmi done");
        apb(1'b1, BMX_OFF_PC, 32'h100, 34'h0);
        insn(F_BR_REL, 3'h0, 16'h00f0);
        wait_done();
        rdx(BMX_OFF_PC, 32'hf2);
        insn(F_A_R, 3'h3, 16'h0000);
        wait_done();
        rdx(BMX_OFF_REGLO, {v[3], v[2], v[3], v[0]});
        insn(F_PSW_A, 3'h0, 16'h0000);
        wait_done();
        rdx(BMX_OFF_PSW, {24'h0, v[3] & 8'h51});
        insn(F_X_SFR, 3'h0, 16'h0080);
        wait_done();
        rdx(BMX_OFF_REGLO, {v[3], v[2], f(16'hff80), v[0]});
        rdx(BMX_OFF_PSW, {24'h0, v[3] & 8'h51});
        $display("test other forms done");
        end_of_test();
    end
endmodule : tb
